// ===== analog_side_model.sv
module analog_side_model
    import converter_control_pkg::*;
#(
    parameter logic [RESULT_W-1:0] SAMPLE_VAL = 10'h2a5
) (
    // clock
    input wire logic aclk,
    // converter side
    input wire logic adc_sample,
    input wire logic dac_update,
    input wire logic [RESULT_W-1:0] dac_value,
    output logic [RESULT_W-1:0] adc_result,
    // observation
    output int sample_cnt,
    output int update_cnt,
    output logic [RESULT_W-1:0] dac_seen
);
    // ------------------------------------------------------------
    // sample and hold
    // ------------------------------------------------------------
    // before the first sample the pins show the inverse, so a result taken
    // without a sample strobe cannot match
    logic held = 1'b0;
    assign adc_result = held ? SAMPLE_VAL : ~SAMPLE_VAL;
    initial begin
        sample_cnt = 0;
        update_cnt = 0;
        dac_seen = '0;
    end
    always @(posedge aclk) begin
        if (adc_sample) begin
            held <= 1'b1;
            sample_cnt <= sample_cnt + 1;
        end
        if (dac_update) begin
            update_cnt <= update_cnt + 1;
            dac_seen <= dac_value;
        end
    end
endmodule

// ===== conv_clock_div.sv
module conv_clock_div
    import converter_control_pkg::*;
#(
    parameter int PRESCALE_BITS = PRESCALE_W
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // selection
    input wire logic [CLKSEL_W-1:0] clk_sel,
    input wire logic rc_tick,
    // converter clock enable pulse
    output logic conv_tick
);
    logic [PRESCALE_BITS-1:0] prescale;
    logic [PRESCALE_BITS:0] mask_wide;
    logic [PRESCALE_BITS-1:0] mask;
    logic div_hit;

    // code 0 uses the rc source, code k divides the system clock by 2^k
    assign mask_wide = ({{PRESCALE_BITS{1'b0}}, 1'b1} << clk_sel) - {{PRESCALE_BITS{1'b0}}, 1'b1};
    assign mask = mask_wide[PRESCALE_BITS-1:0];
    assign div_hit = (prescale & mask) == mask;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prescale <= '0;
            conv_tick <= 1'b0;
        end else begin
            prescale <= prescale + 1'b1;
            conv_tick <= (clk_sel == '0) ? rc_tick : div_hit; // see R9
        end
    end
endmodule

// ===== converter_control_control.sv
// Behaviour
// R1: done flag bit7 set at end, ack clears
// R2: software write of one starts conversion
// R3: busy high during conversion, cleared at end
// R4: hardware trigger also drives busy high
// R5: bit5 selects dac, else adc
// R6: bit4 enables converter, clear disables entirely
// R7: right justified result is sign extended
// R8: left justified result zeroes low bits
// R9: clock select rc/4 or sysclk divided
// R10: control register resets to zero
// R11: adc takes 13 cycles, samples third
// R12: dac takes 11 cycles, propagates cycle seven
// R13: software start only while enabled
// R14: timer overflow starts one conversion
// R15: writing zero to busy never aborts
//
// Added by the designer: register access over AXI4-Lite.
module converter_control_control
    import converter_control_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // clock source and triggers
    input wire logic rc_tick,
    input wire logic [2:0] timer_overflow,
    input wire logic intr_ack,
    // analog side
    input wire logic [RESULT_W-1:0] adc_result,
    output logic adc_sample,
    output logic [RESULT_W-1:0] dac_value,
    output logic dac_update,
    output logic converter_on,
    output logic dac_mode,
    // interrupt
    output logic irq
);
    import converter_control_pkg::*;

    // ------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------
    logic [5:0] ctrl_cfg;
    logic done_flag;
    logic [7:0] input_control;
    logic [7:0] data_low;
    logic [7:0] data_high;
    logic irq_status;
    logic irq_mask;
    conv_state_t state;
    logic [3:0] tick_count;
    logic run_dac;

    // axi holding registers
    logic have_aw;
    logic have_w;
    logic [9:0] wr_index;
    logic [7:0] wr_byte;
    logic wr_lane;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic wr_fire = have_aw && have_w && !s_axi_bvalid;
    wire logic wr_en = wr_fire && wr_lane;
    wire logic wr_ctrl = wr_en && (wr_index == IDX_CONTROL);
    wire logic wr_inctl = wr_en && (wr_index == IDX_INPUT_CONTROL);
    wire logic wr_low = wr_en && (wr_index == IDX_DATA_LOW);
    wire logic wr_high = wr_en && (wr_index == IDX_DATA_HIGH);
    wire logic wr_stat = wr_en && (wr_index == IDX_IRQ_STATUS);
    wire logic wr_mask = wr_en && (wr_index == IDX_IRQ_MASK);
    wire logic wr_mapped = (wr_index == IDX_CONTROL) || (wr_index == IDX_INPUT_CONTROL)
        || (wr_index == IDX_DATA_LOW) || (wr_index == IDX_DATA_HIGH)
        || (wr_index == IDX_IRQ_STATUS) || (wr_index == IDX_IRQ_MASK);

    wire logic enable = ctrl_cfg[BIT_ENABLE]; // see R6
    wire logic mode_dac = ctrl_cfg[BIT_DAC]; // see R5
    wire logic ljust = ctrl_cfg[BIT_LJUST];
    wire logic [CLKSEL_W-1:0] clk_sel = ctrl_cfg[CLKSEL_LSB +: CLKSEL_W];
    wire logic [TRIG_W-1:0] trig_sel = input_control[TRIG_LSB +: TRIG_W];
    wire logic busy = (state == ST_RUN);
    wire logic conv_tick;

    // ------------------------------------------------------------
    // start and completion conditions
    // ------------------------------------------------------------
    wire logic idle_ready = (state == ST_IDLE) && enable;
    // software start needs enable and software trigger mode
    wire logic sw_start = idle_ready && wr_ctrl && wr_byte[BIT_BUSY]
        && (trig_sel == '0); // see R2, R13
    // an overflow of the timer picked by trig_sel starts exactly one conversion
    wire logic hw_start = idle_ready && (trig_sel != '0)
        && timer_overflow[trig_sel - 2'h1]; // see R14
    wire logic start = sw_start || hw_start;
    wire logic [3:0] last_tick = run_dac ? (DAC_CYCLES - 4'h1) : (ADC_CYCLES - 4'h1);
    wire logic done_evt = busy && enable && conv_tick && (tick_count == last_tick);

    // result formatting
    wire logic [15:0] adc_right = {{(16 - RESULT_W){adc_result[RESULT_W-1]}}, adc_result};
    wire logic [15:0] adc_left = {adc_result, {(16 - RESULT_W){1'b0}}};
    wire logic [15:0] adc_fmt = ljust ? adc_left : adc_right; // see R7, R8
    wire logic [15:0] dac_word = {data_high, data_low};
    wire logic [RESULT_W-1:0] dac_pick = ljust ? dac_word[15 -: RESULT_W]
        : dac_word[RESULT_W-1:0];

    // read mux
    wire logic [9:0] rd_index = s_axi_araddr[11:2];
    wire logic data_readable = !mode_dac;
    wire logic [7:0] ctrl_read = {done_flag, busy, ctrl_cfg}; // see R3, R4
    wire logic rd_hit = (rd_index == IDX_CONTROL) || (rd_index == IDX_INPUT_CONTROL)
        || (rd_index == IDX_DATA_LOW) || (rd_index == IDX_DATA_HIGH)
        || (rd_index == IDX_IRQ_STATUS) || (rd_index == IDX_IRQ_MASK);
    wire logic [7:0] rd_byte =
        (rd_index == IDX_CONTROL) ? ctrl_read :
        (rd_index == IDX_INPUT_CONTROL) ? input_control :
        (rd_index == IDX_DATA_LOW && data_readable) ? data_low :
        (rd_index == IDX_DATA_HIGH && data_readable) ? data_high :
        (rd_index == IDX_IRQ_STATUS) ? {7'h00, irq_status} :
        (rd_index == IDX_IRQ_MASK) ? {7'h00, irq_mask} : 8'h00;

    assign s_axi_awready = !have_aw && !s_axi_bvalid;
    assign s_axi_wready = !have_w && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign converter_on = enable;
    assign dac_mode = mode_dac;
    assign irq = irq_status && irq_mask;

    // ------------------------------------------------------------
    // converter clock
    // ------------------------------------------------------------
    conv_clock_div #(
        .PRESCALE_BITS(PRESCALE_W)
    ) u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_sel(clk_sel),
        .rc_tick(rc_tick),
        .conv_tick(conv_tick)
    );

    // ------------------------------------------------------------
    // axi write channel
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            have_aw <= 1'b0;
            have_w <= 1'b0;
            wr_index <= '0;
            wr_byte <= 8'h00;
            wr_lane <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                have_aw <= 1'b1;
                wr_index <= s_axi_awaddr[11:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                have_w <= 1'b1;
                wr_byte <= s_axi_wdata[7:0];
                wr_lane <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                have_aw <= 1'b0;
                have_w <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // axi read channel
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    // busy and done bits are hardware owned, so a written zero there
    // never disturbs a running conversion
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_cfg <= RST_CONTROL[5:0]; // see R10
            input_control <= RST_INPUT_CONTROL;
            irq_mask <= RST_IRQ;
        end else begin
            if (wr_ctrl) begin
                ctrl_cfg <= wr_byte[5:0]; // see R15
            end
            if (wr_inctl) begin
                input_control <= wr_byte;
            end
            if (wr_mask) begin
                irq_mask <= wr_byte[0];
            end
        end
    end

    // ------------------------------------------------------------
    // done flag and interrupt status, set wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_flag <= RST_CONTROL[BIT_DONE];
            irq_status <= RST_IRQ;
        end else begin
            done_flag <= done_evt || (done_flag && !intr_ack); // see R1
            irq_status <= done_evt || (irq_status && !(wr_stat && wr_byte[0]));
        end
    end

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            tick_count <= 4'h0;
            run_dac <= 1'b0;
            dac_value <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    tick_count <= 4'h0;
                    if (start) begin
                        state <= ST_RUN; // see R3, R4
                        run_dac <= mode_dac;
                        if (mode_dac) begin
                            dac_value <= dac_pick;
                        end
                    end
                end
                ST_RUN: begin
                    // disabling drops the conversion at once
                    if (!enable || done_evt) begin
                        state <= ST_IDLE; // see R3, R6
                    end else if (conv_tick) begin
                        tick_count <= tick_count + 4'h1; // see R11, R12
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // analog strobes and data registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            adc_sample <= 1'b0;
            dac_update <= 1'b0;
        end else begin
            // a conversion dropped by disable must not strobe on its way out
            adc_sample <= busy && enable && !run_dac && conv_tick
                && (tick_count == ADC_SAMPLE_CYCLE - 4'h1); // see R11
            dac_update <= busy && enable && run_dac && conv_tick
                && (tick_count == DAC_PROPAGATE_CYCLE - 4'h1); // see R12
        end
    end

    // data is read-only in adc mode and write-only in dac mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_low <= RST_DATA;
            data_high <= RST_DATA;
        end else if (done_evt && !run_dac) begin
            data_low <= adc_fmt[7:0]; // see R7, R8
            data_high <= adc_fmt[15:8];
        end else if (mode_dac) begin
            if (wr_low) begin
                data_low <= wr_byte;
            end
            if (wr_high) begin
                data_high <= wr_byte;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_done_set;
        done_evt |=> done_flag && ctrl_read[BIT_DONE];
    endproperty
    a_done_set: assert property (p_done_set) else $error("done flag not set"); // see R1

    property p_sw_start;
        sw_start |=> busy && ctrl_read[BIT_BUSY] && tick_count == 4'h0;
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("software start ignored"); // see R2

    property p_busy_clear;
        done_evt |=> !ctrl_read[BIT_BUSY] ##1 (!busy || $past(start));
    endproperty
    a_busy_clear: assert property (p_busy_clear) else $error("busy not cleared"); // see R3

    property p_hw_start;
        (state == ST_IDLE) && enable && trig_sel == 2'h2 && timer_overflow[1] |=> busy;
    endproperty
    a_hw_start: assert property (p_hw_start) else $error("timer start missed"); // see R14

    property p_disable;
        !enable |=> !busy && !adc_sample && !dac_update;
    endproperty
    a_disable: assert property (p_disable) else $error("runs while disabled"); // see R6

    property p_right;
        done_evt && !run_dac && !ljust |=>
            data_high[7:2] == {6{$past(adc_result[RESULT_W-1])}} && data_low == $past(adc_result[7:0]);
    endproperty
    a_right: assert property (p_right) else $error("right justify wrong"); // see R7

    property p_left;
        done_evt && !run_dac && ljust |=> data_low[5:0] == 6'h00
            && data_high == $past(adc_result[9:2]);
    endproperty
    a_left: assert property (p_left) else $error("left justify wrong"); // see R8

    property p_no_abort;
        busy && !done_evt && wr_ctrl && wr_byte[BIT_ENABLE] && !wr_byte[BIT_BUSY] |=> busy;
    endproperty
    a_no_abort: assert property (p_no_abort) else $error("zero write aborted"); // see R15

    property p_dac_strobe;
        dac_update |-> run_dac && busy && tick_count == DAC_PROPAGATE_CYCLE;
    endproperty
    a_dac_strobe: assert property (p_dac_strobe) else $error("dac update misplaced"); // see R12

    property p_adc_strobe;
        adc_sample |-> !run_dac && tick_count == ADC_SAMPLE_CYCLE;
    endproperty
    a_adc_strobe: assert property (p_adc_strobe) else $error("adc sample misplaced"); // see R11

    property p_no_start_off;
        !enable && wr_ctrl && wr_byte[BIT_BUSY] && !busy |=> !busy;
    endproperty
    a_no_start_off: assert property (p_no_start_off) else $error("start while off"); // see R13

endmodule

// ===== converter_control_pkg.sv
package converter_control_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_CONTROL = 10'h0d9;
    localparam logic [9:0] IDX_INPUT_CONTROL = 10'h0da;
    localparam logic [9:0] IDX_DATA_LOW = 10'h0dc;
    localparam logic [9:0] IDX_DATA_HIGH = 10'h0dd;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h0e0;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h0e1;

    // ------------------------------------------------------------
    // converter_control fields
    // ------------------------------------------------------------
    localparam int BIT_DONE = 7;
    localparam int BIT_BUSY = 6;
    localparam int BIT_DAC = 5;
    localparam int BIT_ENABLE = 4;
    localparam int BIT_LJUST = 3;
    localparam int CLKSEL_LSB = 0;
    localparam int CLKSEL_W = 3;

    // input control: trigger select field
    localparam int TRIG_LSB = 4;
    localparam int TRIG_W = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_INPUT_CONTROL = 8'h00;
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [0:0] RST_IRQ = 1'h0;

    // ------------------------------------------------------------
    // conversion timing in converter clock cycles
    // ------------------------------------------------------------
    localparam logic [3:0] ADC_CYCLES = 4'hd;
    localparam logic [3:0] DAC_CYCLES = 4'hb;
    localparam logic [3:0] ADC_SAMPLE_CYCLE = 4'h3;
    localparam logic [3:0] DAC_PROPAGATE_CYCLE = 4'h7;

    localparam int RESULT_W = 10;
    localparam int PRESCALE_W = 7;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } conv_state_t;

endpackage

// ===== tb_adc_dac_control.sv
module tb_adc_dac_control;
    timeunit 1ns;
    timeprecision 1ps;
    import converter_control_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam logic [11:0] A_CTL = {IDX_CONTROL, 2'b00};
    localparam logic [11:0] A_INP = {IDX_INPUT_CONTROL, 2'b00};
    localparam logic [11:0] A_LO = {IDX_DATA_LOW, 2'b00};
    localparam logic [11:0] A_HI = {IDX_DATA_HIGH, 2'b00};
    localparam logic [11:0] A_STA = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [11:0] A_MSK = {IDX_IRQ_MASK, 2'b00};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h0;
    logic [11:0] araddr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic rc_tick = 1'b0;
    logic [2:0] rc_cnt = 3'h0;
    logic [2:0] timer_overflow = 3'h0;
    logic intr_ack = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic adc_sample, dac_update, converter_on, dac_mode;
    logic [1:0] bresp, rresp, last_resp;
    logic [31:0] rdata, rd;
    logic [RESULT_W-1:0] adc_result, dac_value, dac_seen;
    int sample_cnt, update_cnt, error_cnt, checks;

    converter_control_control u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rc_tick(rc_tick), .timer_overflow(timer_overflow),
        .intr_ack(intr_ack), .adc_result(adc_result), .adc_sample(adc_sample),
        .dac_value(dac_value), .dac_update(dac_update), .converter_on(converter_on),
        .dac_mode(dac_mode), .irq(irq));

    analog_side_model u_model (.aclk(aclk), .adc_sample(adc_sample),
        .dac_update(dac_update), .dac_value(dac_value), .adc_result(adc_result),
        .sample_cnt(sample_cnt), .update_cnt(update_cnt), .dac_seen(dac_seen));

    initial begin
        forever #5 aclk = ~aclk;
    end
    // rc/4 stand-in: one pulse every 8 system cycles keeps the run short
    always @(posedge aclk) begin
        rc_cnt <= rc_cnt + 3'h1;
        rc_tick <= (rc_cnt == 3'h7);
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        if (error_cnt == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic timeout;
        chk(32'h0, 32'h1);
        test_done();
    endtask
    function automatic logic [31:0] in_rng(int v, int lo, int hi);
        return {31'h0, v >= lo && v <= hi};
    endfunction
    // ready is registered state, so the level seen at the falling edge
    // is the one sampled at the next rising edge
    task automatic axi_wr(input logic [11:0] a, input logic [7:0] d);
        logic aw_done, w_done, b_hit;
        int n;
        aw_done = 1'b0;
        w_done = 1'b0;
        b_hit = 1'b0;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40 && !(aw_done && w_done && b_hit); n++) begin
            @(negedge aclk);
            if (!aw_done && awready) aw_done = 1'b1;
            if (!w_done && wready) w_done = 1'b1;
            if (bvalid) b_hit = 1'b1;
            last_resp = bresp;
            @(posedge aclk);
            if (aw_done && awvalid) awvalid <= 1'b0;
            if (w_done && wvalid) wvalid <= 1'b0;
        end
        if (!b_hit) timeout();
    endtask
    task automatic axi_rd(input logic [11:0] a);
        logic ar_done, r_hit;
        int n;
        ar_done = 1'b0;
        r_hit = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40 && !r_hit; n++) begin
            @(negedge aclk);
            if (!ar_done && arready) ar_done = 1'b1;
            if (rvalid) r_hit = 1'b1;
            rd = rdata;
            last_resp = rresp;
            @(posedge aclk);
            if (ar_done && arvalid) arvalid <= 1'b0;
        end
        if (!r_hit) timeout();
    endtask
    task automatic wait_irq(output int cyc);
        for (cyc = 0; cyc < 4000; cyc++) begin
            @(negedge aclk);
            if (irq === 1'b1) break;
        end
        @(posedge aclk);
        if (cyc == 4000) timeout();
    endtask
    task automatic ack_all;
        axi_wr(A_STA, 8'h01);
        intr_ack <= 1'b1;
        @(posedge aclk);
        intr_ack <= 1'b0;
        @(negedge aclk);
        chk(irq, 1'b0);
        @(posedge aclk);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        axi_rd(A_CTL);
        chk(rd, RST_CONTROL);
        axi_rd(A_LO);
        chk(rd, 32'h0);
        axi_rd(12'hffc);
        chk(last_resp, RESP_SLVERR);
        axi_wr(12'hffc, 8'hff);
        chk(last_resp, RESP_SLVERR);
        axi_wr(A_CTL, 8'h40);
        axi_rd(A_CTL);
        chk(rd, 32'h0);
        axi_wr(A_MSK, 8'h01);
        axi_rd(A_MSK);
        chk(rd, 32'h1);
    endtask
    task automatic t_adc_right;
        int c, s0;
        s0 = sample_cnt;
        axi_wr(A_CTL, 8'h11);
        axi_wr(A_CTL, 8'h51);
        axi_rd(A_CTL);
        chk(rd, 32'h51);
        axi_wr(A_CTL, 8'h11);
        axi_rd(A_CTL);
        chk(rd, 32'h51);
        wait_irq(c);
        axi_rd(A_CTL);
        chk(rd, 32'h91);
        axi_rd(A_LO);
        chk(rd, 32'ha5);
        axi_rd(A_HI);
        chk(rd, 32'hfe);
        chk(sample_cnt - s0, 1);
        ack_all();
        axi_rd(A_CTL);
        chk(rd, 32'h11);
    endtask
    task automatic t_adc_left;
        int c;
        axi_wr(A_CTL, 8'h19);
        axi_wr(A_CTL, 8'h59);
        wait_irq(c);
        axi_rd(A_LO);
        chk(rd, 32'h40);
        axi_rd(A_HI);
        chk(rd, 32'ha9);
        ack_all();
    endtask
    task automatic t_clock_sel;
        int c, p;
        for (int k = 0; k < 8; k++) begin
            p = (k == 0) ? 8 : (1 << k);
            axi_wr(A_CTL, 8'h10 | 8'(k));
            axi_wr(A_CTL, 8'h50 | 8'(k));
            wait_irq(c);
            chk(in_rng(c, 12 * p - 2, 13 * p + 2), 32'h1);
            ack_all();
        end
    endtask
    task automatic t_dac;
        int c, u0;
        u0 = update_cnt;
        axi_wr(A_CTL, 8'h31);
        axi_wr(A_LO, 8'h5a);
        axi_wr(A_HI, 8'h01);
        axi_wr(A_CTL, 8'h71);
        chk(dac_mode, 1'b1);
        wait_irq(c);
        chk(in_rng(c, 20, 24), 32'h1);
        chk(update_cnt - u0, 1);
        chk(dac_seen, 10'h15a);
        axi_rd(A_LO);
        chk(rd, 32'h0);
        ack_all();
    endtask
    task automatic t_timer;
        int c;
        axi_wr(A_CTL, 8'h11);
        axi_wr(A_INP, 8'h20);
        timer_overflow <= 3'h1;
        @(posedge aclk);
        timer_overflow <= 3'h0;
        axi_rd(A_CTL);
        chk(rd, 32'h11);
        timer_overflow <= 3'h2;
        @(posedge aclk);
        timer_overflow <= 3'h0;
        axi_rd(A_CTL);
        chk(rd, 32'h51);
        wait_irq(c);
        ack_all();
        axi_wr(A_INP, 8'h00);
    endtask
    task automatic t_abort;
        axi_wr(A_CTL, 8'h51);
        axi_wr(A_CTL, 8'h01);
        axi_rd(A_CTL);
        chk(rd, 32'h01);
        chk(converter_on, 1'b0);
        repeat (60) @(posedge aclk);
        @(negedge aclk);
        chk(irq, 1'b0);
        @(posedge aclk);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        error_cnt = 0;
        checks = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_adc_right();
        t_adc_left();
        t_clock_sel();
        t_dac();
        t_timer();
        axi_wr(A_CTL, 8'h11);
        t_abort();
        test_done();
    end
endmodule
